/* File: design/rcs_flag_bank.sv */
`timescale 1ns/1ps
`include "rcs_map.svh"

// sticky flag bank: hardware sets, software loads or clears by writing one
module rcs_flag_bank #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000,
  parameter logic [31:0] WMASK     = 32'h0000_0000,
  parameter logic [31:0] HWMASK    = 32'h0000_0000,
  parameter bit          W1C       = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] set_i,
  output logic      [31:0] flags_o
);

  rcs_pkg::rcs_bank_state_type state_reg;
  rcs_pkg::rcs_bank_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_i) begin
      if (W1C) begin
        state_next.flags = state_reg.flags & ~(wdata_i & WMASK);
      end else begin
        state_next.flags = (state_reg.flags & ~WMASK) | (wdata_i & WMASK); // R12
      end
    end
    // set is applied last so an event in the clearing cycle is kept
    state_next.flags = (state_next.flags | (set_i & HWMASK)) & WMASK; // R11 R12
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg.flags <= RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags_o = state_reg.flags;

endmodule

/* File: design/rcs_map.svh */
// Behaviour
// R1 - set high-voltage reset flag, bit 29, when regulator output exceeded 2.5 V
// R2 - set configuration mismatch flag, bit 9, only on a mismatch reset
// R3 - regulator standby enable, bit 8, keeps the regulator on during sleep
// R4 - set external pin reset flag, bit 7, on a master-clear pin reset
// R5 - set software reset flag, bit 6, when a software reset executed
// R6 - set watchdog time-out flag, bit 4, when the watchdog expires
// R7 - set sleep flag, bit 3, when the device was asleep before wake or reset
// R8 - set idle flag, bit 2, when the device was idle before wake or reset
// R9 - set brown-out flag, bit 1, on brown-out; reads one after power-on
// R10 - set power-on flag, bit 0, on power-on; reads one after power-on
// R11 - undefined positions, bits 28-10 and others, read zero and ignore writes
// R12 - flags are set only by hardware; software may read and write them; here a software write of one also sets a flag
// R13 - a set flag survives later resets of other kinds until software writes it
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RCS_ADDR_W          8
`define RCS_OFS_CAUSE       8'h00
`define RCS_OFS_IRQ_STATUS  8'h04
`define RCS_OFS_IRQ_MASK    8'h08

// ----------------------------------------------------------------
// field positions of the cause register
// ----------------------------------------------------------------
`define RCS_BIT_HV_RESET    29
`define RCS_BIT_CFG_MISM    9
`define RCS_BIT_REG_STBY    8
`define RCS_BIT_EXT_PIN     7
`define RCS_BIT_SW_RESET    6
`define RCS_BIT_WDOG_TO     4
`define RCS_BIT_SLEEP       3
`define RCS_BIT_IDLE        2
`define RCS_BIT_BROWNOUT    1
`define RCS_BIT_POWER_ON    0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define RCS_CAUSE_WMASK     32'h2000_03df
`define RCS_CAUSE_HWMASK    32'h2000_02df
`define RCS_CAUSE_RESET     32'h0000_0003
`define RCS_IRQ_RESET       32'h0000_0000
`define RCS_HV_LIMIT_MV     2500

`endif

/* File: design/rcs_pkg.sv */
package rcs_pkg;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rcs_bus_req_type;

  typedef struct packed {
    logic hv_detect;
    logic cfg_mismatch;
    logic ext_pin;
    logic sw_reset;
    logic wdog_timeout;
    logic brownout;
    logic wake;
    logic enter_sleep;
    logic enter_idle;
  } rcs_event_type;

  typedef enum logic [1:0] {
    RCS_PM_RUN,
    RCS_PM_IDLE,
    RCS_PM_SLEEP
  } rcs_pm_type;

  typedef struct packed {
    logic [31:0] flags;
  } rcs_bank_state_type;

  typedef struct packed {
    rcs_pm_type  pm;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic        irq;
    logic        reg_on;
  } rcs_top_state_type;

endpackage

/* File: design/rcs_top.sv */
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "rcs_map.svh"

module rcs_top (
  input  wire logic                    clk_i,
  input  wire logic                    rstn_i,
  input  wire rcs_pkg::rcs_bus_req_type bus_i,
  input  wire rcs_pkg::rcs_event_type   event_i,
  output logic                   [31:0] rdata_o,
  output logic                          irq_o,
  output logic                          regulator_on_o,
  output logic                   [31:0] reset_cause_status_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // any event after which the device is running again
  function automatic logic is_resume(input rcs_pkg::rcs_event_type ev);
    is_resume = ev.wake | ev.hv_detect | ev.cfg_mismatch | ev.ext_pin |
                ev.sw_reset | ev.wdog_timeout | ev.brownout;
  endfunction

  // ----------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------
  logic        wr_cause;
  logic        wr_status;
  logic        wr_mask;
  logic [31:0] cause_flags;
  logic [31:0] irq_flags;
  logic [31:0] set_vec;

  assign wr_cause  = bus_i.wr && addr_hit(bus_i.addr, `RCS_OFS_CAUSE);
  assign wr_status = bus_i.wr && addr_hit(bus_i.addr, `RCS_OFS_IRQ_STATUS);
  assign wr_mask   = bus_i.wr && addr_hit(bus_i.addr, `RCS_OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // power mode tracking
  // ----------------------------------------------------------------
  rcs_pkg::rcs_top_state_type state_reg;
  rcs_pkg::rcs_top_state_type state_next;

  // ----------------------------------------------------------------
  // hardware set vector
  // ----------------------------------------------------------------
  always_comb begin
    set_vec                       = 32'h0000_0000;
    set_vec[`RCS_BIT_HV_RESET]    = event_i.hv_detect; // R1
    set_vec[`RCS_BIT_CFG_MISM]    = event_i.cfg_mismatch; // R2
    set_vec[`RCS_BIT_EXT_PIN]     = event_i.ext_pin; // R4
    set_vec[`RCS_BIT_SW_RESET]    = event_i.sw_reset; // R5
    set_vec[`RCS_BIT_WDOG_TO]     = event_i.wdog_timeout; // R6
    set_vec[`RCS_BIT_BROWNOUT]    = event_i.brownout; // R9
    // the mode recorded is the one held before this event
    set_vec[`RCS_BIT_SLEEP]       = is_resume(event_i) &&
                                    (state_reg.pm == rcs_pkg::RCS_PM_SLEEP); // R7
    set_vec[`RCS_BIT_IDLE]        = is_resume(event_i) &&
                                    (state_reg.pm == rcs_pkg::RCS_PM_IDLE); // R8
  end

  // ----------------------------------------------------------------
  // flag banks
  // ----------------------------------------------------------------
  // only the power-on reset clears these; other resets arrive as events (R13)
  rcs_flag_bank #(
    .RESET_VAL (`RCS_CAUSE_RESET),
    .WMASK     (`RCS_CAUSE_WMASK),
    .HWMASK    (`RCS_CAUSE_HWMASK),
    .W1C       (1'b0)
  ) u_cause (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_i    (wr_cause),
    .wdata_i (bus_i.wdata),
    .set_i   (set_vec),
    .flags_o (cause_flags)
  ); // R9 R10 R13

  rcs_flag_bank #(
    .RESET_VAL (`RCS_IRQ_RESET),
    .WMASK     (`RCS_CAUSE_HWMASK),
    .HWMASK    (`RCS_CAUSE_HWMASK),
    .W1C       (1'b1)
  ) u_irq (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .wr_i    (wr_status),
    .wdata_i (bus_i.wdata),
    .set_i   (set_vec),
    .flags_o (irq_flags)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg.pm)
      rcs_pkg::RCS_PM_RUN: begin
        if (event_i.enter_sleep) begin
          state_next.pm = rcs_pkg::RCS_PM_SLEEP;
        end else if (event_i.enter_idle) begin
          state_next.pm = rcs_pkg::RCS_PM_IDLE;
        end
      end
      rcs_pkg::RCS_PM_IDLE,
      rcs_pkg::RCS_PM_SLEEP: begin
        if (is_resume(event_i)) begin
          state_next.pm = rcs_pkg::RCS_PM_RUN;
        end
      end
      default: begin
        state_next.pm = rcs_pkg::RCS_PM_RUN;
      end
    endcase

    if (wr_mask) begin
      state_next.mask = bus_i.wdata & `RCS_CAUSE_HWMASK;
    end

    // read data is valid only in the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      if (addr_hit(bus_i.addr, `RCS_OFS_CAUSE)) begin
        state_next.rdata = cause_flags; // R11
      end else if (addr_hit(bus_i.addr, `RCS_OFS_IRQ_STATUS)) begin
        state_next.rdata = irq_flags;
      end else if (addr_hit(bus_i.addr, `RCS_OFS_IRQ_MASK)) begin
        state_next.rdata = state_reg.mask;
      end
    end

    state_next.irq = |(irq_flags & state_reg.mask);

    // standby enable off: regulator drops while asleep
    state_next.reg_on = !((state_next.pm == rcs_pkg::RCS_PM_SLEEP) &&
                          !cause_flags[`RCS_BIT_REG_STBY]); // R3
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg.pm     <= rcs_pkg::RCS_PM_RUN;
      state_reg.mask   <= `RCS_IRQ_RESET;
      state_reg.rdata  <= 32'h0000_0000;
      state_reg.irq    <= 1'b0;
      state_reg.reg_on <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o              = state_reg.rdata;
  assign irq_o                = state_reg.irq;
  assign regulator_on_o       = state_reg.reg_on;
  assign reset_cause_status_o = cause_flags;

endmodule

/* File: testbench/rcs_top_asserts.sv */
`timescale 1ns/1ps
module rcs_top_asserts (
  input wire logic                     clk_i,
  input wire logic                     rstn_i,
  input wire rcs_pkg::rcs_bus_req_type bus_i,
  input wire rcs_pkg::rcs_event_type   event_i,
  input wire logic              [31:0] rdata_o,
  input wire logic                     irq_o,
  input wire logic                     regulator_on_o,
  input wire logic              [31:0] reset_cause_status_o
);
  // --------------------------------------------------------------
  // flag relations
  // --------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire cause_wr = bus_i.wr && bus_i.addr == 8'h00;
  AST_HV: assert property (event_i.hv_detect |=> reset_cause_status_o[29])
    else $error("hv flag not set");
  AST_CFG: assert property (event_i.cfg_mismatch |=> reset_cause_status_o[9])
    else $error("mismatch flag not set");
  AST_EXT: assert property (event_i.ext_pin |=> reset_cause_status_o[7])
    else $error("pin flag not set");
  AST_SW: assert property (event_i.sw_reset |=> reset_cause_status_o[6])
    else $error("sw flag not set");
  AST_WD: assert property (event_i.wdog_timeout |=> reset_cause_status_o[4])
    else $error("watchdog flag not set");
  AST_BO: assert property (event_i.brownout |=> reset_cause_status_o[1])
    else $error("brownout flag not set");
  AST_RSV: assert property ((reset_cause_status_o & 32'hdfff_fc20) == 32'h0)
    else $error("reserved bit set");
  // apart from reset, a write to the cause register is the only way to lose a flag
  AST_KEEP: assert property (!cause_wr |=>
    (reset_cause_status_o & $past(reset_cause_status_o)) == $past(reset_cause_status_o))
    else $error("flag lost");
  AST_REG: assert property ($fell(regulator_on_o) |->
    $past(event_i.enter_sleep) && !$past(reset_cause_status_o[8]))
    else $error("regulator dropped wrongly");
  AST_WAKE: assert property ($rose(regulator_on_o) |-> reset_cause_status_o[3])
    else $error("sleep flag missing on wake");
  AST_RD: assert property (bus_i.rd && bus_i.addr == 8'h00 |=>
    rdata_o == $past(reset_cause_status_o))
    else $error("cause read mismatch");
endmodule

/* File: testbench/rcs_top_bench.sv */
`timescale 1ns/1ps
module rcs_top_bench;
  logic                     clk_i;
  logic                     rstn_i;
  rcs_pkg::rcs_bus_req_type bus;
  rcs_pkg::rcs_event_type   ev;
  logic              [31:0] rdata;
  logic                     irq;
  logic                     reg_on;
  logic              [31:0] cause;
  logic              [31:0] exp;
  int                       bad_count;
  int                       num_checks;
  int                       bits [6] = '{29, 9, 7, 6, 4, 1};

  rcs_top rcs_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .event_i(ev),
    .rdata_o(rdata), .irq_o(irq), .regulator_on_o(reg_on), .reset_cause_status_o(cause));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask

  task automatic pulse(input logic [8:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 9'h0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    rstn_i = 1'b0;
    bus = '0;
    ev = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(8'h00, 32'h0000_0003);
    chk_bit("regulator", 1'b1, reg_on);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h2000_03df);
    wr(8'h00, 32'h0);
    exp = 32'h0;
    // flags accumulate: no event may wipe an earlier cause
    for (int k = 0; k < 6; k++) begin
      pulse(9'h100 >> k);
      exp[bits[k]] = 1'b1;
      chk("cause flags", exp, cause);
    end
    rd(8'h04, 32'h2000_02d2);
    chk_bit("irq masked", 1'b0, irq);
    wr(8'h08, 32'h0000_0010);
    rd(8'h08, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit("irq raised", 1'b1, irq);
    wr(8'h04, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit("irq cleared", 1'b0, irq);
    pulse(9'h002);
    chk_bit("regulator", 1'b0, reg_on);
    pulse(9'h004);
    exp[3] = 1'b1;
    chk("cause flags", exp, cause);
    pulse(9'h001);
    pulse(9'h004);
    exp[2] = 1'b1;
    chk("cause flags", exp, cause);
    wr(8'h00, 32'h0000_0100);
    pulse(9'h002);
    chk_bit("regulator", 1'b1, reg_on);
    pulse(9'h004);
    chk("cause flags", 32'h0000_0108, cause);
    rd(8'h0c, 32'h0);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(8'h00, 32'h0000_0003);
    stop_test();
  end
endmodule

bind rcs_top rcs_top_asserts rcs_top_asserts_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .bus_i(bus_i), .event_i(event_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .regulator_on_o(regulator_on_o), .reset_cause_status_o(reset_cause_status_o));
